//--- rtl/mlev_cmp.sv
// Unsigned limit comparator for one reading
`timescale 1ns/1ps
`default_nettype none
module mlev_cmp
  import mlev_pkg::*;
(
  input  wire logic         is_temp,
  input  wire logic [7:0]   value,
  input  wire logic [7:0]   high_limit,
  input  wire logic [7:0]   low_limit,
  input  wire logic [7:0]   ot_limit,
  output mlev_pkg::mlev_hits_t hits
);
  always_comb begin
    hits.hi = value > high_limit;
    hits.lo = value < low_limit;
    // Only thermistor channels carry an overtemperature check
    hits.ot = is_temp && (value > ot_limit);
  end
endmodule
`default_nettype wire

//--- rtl/mlev_pkg.sv
// Package for the monitor limit, event and bank block: map, fields, resets and carriers
package mlev_pkg;

  // Bank structure
  localparam int NUM_BANKS       = 13;
  localparam int FIRST_TEMP_BANK = 10;
  localparam int BANK_W          = 4;

  // Common register offsets
  localparam logic [3:0] OFS_EVT_STS0   = 4'h0;
  localparam logic [3:0] OFS_EVT_STS1   = 4'h1;
  localparam logic [3:0] OFS_SMI_EN0    = 4'h2;
  localparam logic [3:0] OFS_SMI_EN1    = 4'h3;
  localparam logic [3:0] OFS_IRQ_EN0    = 4'h4;
  localparam logic [3:0] OFS_IRQ_EN1    = 4'h5;
  localparam logic [3:0] OFS_VID        = 4'h6;
  localparam logic [3:0] OFS_CONV_RATE  = 4'h7;
  localparam logic [3:0] OFS_MON_CFG    = 4'h8;
  localparam logic [3:0] OFS_BANK_SEL   = 4'h9;
  // Banked register offsets
  localparam logic [3:0] OFS_CH_CFGSTS  = 4'hA;
  localparam logic [3:0] OFS_CH_READOUT = 4'hB;
  localparam logic [3:0] OFS_CH_HIGH    = 4'hC;
  localparam logic [3:0] OFS_CH_LOW     = 4'hD;
  localparam logic [3:0] OFS_CH_OT      = 4'hE;

  // Values after reset
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam logic [7:0]  RST_CONV_RATE = 8'h00;
  localparam logic [7:0]  RST_HIGH      = 8'hFF;
  localparam logic [7:0]  RST_LOW       = 8'h00;
  localparam logic [7:0]  RST_OT        = 8'hFF;
  localparam logic [3:0]  RST_BANK      = 4'h0;

  // Monitor configuration fields
  localparam int CFG_STANDBY = 0;
  localparam int CFG_INT_REF = 1;
  localparam logic [7:0] CFG_MASK = 8'h03;

  // Channel configuration/status fields
  localparam int CCS_ALERT_EN = 0;
  localparam int CCS_OTS_EN   = 1;
  localparam int CCS_HIGH     = 4;
  localparam int CCS_LOW      = 5;
  localparam int CCS_OT       = 6;

  // Voltage ID: low bits follow the pins, high bits are storage
  localparam int VID_PIN_W = 6;

  // Event status 1 layout
  localparam int STS1_VOLT_BITS  = 2;
  localparam int STS1_TEMP_FIRST = 3;
  localparam int STS0_W          = 8;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } mlev_bus_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] chan;
    logic [7:0] value;
  } mlev_sample_t;

  typedef struct packed {
    logic hi;
    logic lo;
    logic ot;
  } mlev_hits_t;

  function automatic logic wr_hit(mlev_bus_t b, logic [3:0] ofs);
    return b.wr && (b.addr == ofs);
  endfunction

endpackage

//--- rtl/mlev_top.sv
// Limit checking, event routing and banked register file of the monitor
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module mlev_top
  import mlev_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire mlev_pkg::mlev_bus_t   bus,
  output logic [7:0]                 rd_data,
  input  wire mlev_pkg::mlev_sample_t sample,
  input  wire logic [5:0]            vid_pins,
  input  wire logic                  tms_int_ref,
  output logic [7:0]                 conv_rate_out,
  output logic                       meas_run,
  output logic                       vref_internal,
  output logic                       irq,
  output logic                       smi,
  output logic                       ots_n,
  output logic                       alert
);
  import mlev_pkg::*;

  // Common registers
  logic [7:0]               smi_enable_0;
  logic [7:0]               smi_enable_1;
  logic [7:0]               irq_enable_0;
  logic [7:0]               irq_enable_1;
  logic [7:0]               vid_store;
  logic [7:0]               conversion_rate;
  logic [7:0]               monitor_config;
  logic [BANK_W-1:0]        bank_select;

  // Banked registers
  logic [7:0]               channel_readout    [NUM_BANKS];
  logic [7:0]               channel_high_limit [NUM_BANKS];
  logic [7:0]               channel_low_limit  [NUM_BANKS];
  logic [7:0]               overtemp_limit     [NUM_BANKS];
  logic [NUM_BANKS-1:0]     alert_en;
  logic [NUM_BANKS-1:0]     ots_en;
  logic [NUM_BANKS-1:0]     high_exceeded_flag;
  logic [NUM_BANKS-1:0]     low_exceeded_flag;
  logic [NUM_BANKS-1:0]     ot_flag;

  // Derived terms
  logic                     bank_ok;
  logic                     standby;
  logic                     take_sample;
  logic [NUM_BANKS-1:0]     chan_event;
  logic [7:0]               event_status_0;
  logic [7:0]               event_status_1;
  logic [7:0]               channel_config_status;
  logic [7:0]               next_rd_data;
  mlev_hits_t               hits;
  logic                     smp_is_temp;
  logic [7:0]               smp_high;
  logic [7:0]               smp_low;
  logic [7:0]               smp_ot;

  // Banked accesses outside the 13 banks are ignored and read zero
  assign bank_ok = bank_select < BANK_W'(NUM_BANKS);
  assign standby = monitor_config[CFG_STANDBY];

  // A reading for a nonexistent channel is dropped
  assign take_sample = sample.valid && !standby
                       && (sample.chan < BANK_W'(NUM_BANKS));
  assign smp_is_temp = take_sample && (sample.chan >= BANK_W'(FIRST_TEMP_BANK));

  always_comb begin
    smp_high = RST_HIGH;
    smp_low  = RST_LOW;
    smp_ot   = RST_OT;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (sample.chan == BANK_W'(i)) begin
        smp_high = channel_high_limit[i];
        smp_low  = channel_low_limit[i];
        smp_ot   = overtemp_limit[i];
      end
    end
  end

  mlev_cmp u_cmp (
    .is_temp    (smp_is_temp),
    .value      (sample.value),
    .high_limit (smp_high),
    .low_limit  (smp_low),
    .ot_limit   (smp_ot),
    .hits       (hits)
  );

  // Event status views of the sticky flags
  assign chan_event = high_exceeded_flag | low_exceeded_flag | ot_flag;

  always_comb begin
    event_status_0 = RST_ZERO;
    event_status_1 = RST_ZERO;
    for (int i = 0; i < STS0_W; i++) begin
      event_status_0[i] = chan_event[i];
    end
    for (int i = 0; i < STS1_VOLT_BITS; i++) begin
      event_status_1[i] = chan_event[STS0_W + i];
    end
    for (int i = 0; i < NUM_BANKS - FIRST_TEMP_BANK; i++) begin
      event_status_1[STS1_TEMP_FIRST + i] = chan_event[FIRST_TEMP_BANK + i];
    end
  end

  // Configuration/status of the selected bank
  always_comb begin
    channel_config_status = RST_ZERO;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (bank_select == BANK_W'(i)) begin
        channel_config_status[CCS_ALERT_EN] = alert_en[i];
        channel_config_status[CCS_OTS_EN]   = ots_en[i];
        channel_config_status[CCS_HIGH]     = high_exceeded_flag[i];
        channel_config_status[CCS_LOW]      = low_exceeded_flag[i];
        channel_config_status[CCS_OT]       = ot_flag[i];
      end
    end
  end

  // Common registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      smi_enable_0    <= RST_ZERO;
      smi_enable_1    <= RST_ZERO;
      irq_enable_0    <= RST_ZERO;
      irq_enable_1    <= RST_ZERO;
      conversion_rate <= RST_CONV_RATE;
      monitor_config  <= RST_ZERO;
    end else begin
      if (wr_hit(bus, OFS_SMI_EN0)) begin
        smi_enable_0 <= bus.wdata;
      end
      if (wr_hit(bus, OFS_SMI_EN1)) begin
        smi_enable_1 <= bus.wdata;
      end
      if (wr_hit(bus, OFS_IRQ_EN0)) begin
        irq_enable_0 <= bus.wdata;
      end
      if (wr_hit(bus, OFS_IRQ_EN1)) begin
        irq_enable_1 <= bus.wdata;
      end
      if (wr_hit(bus, OFS_CONV_RATE)) begin
        conversion_rate <= bus.wdata;
      end
      if (wr_hit(bus, OFS_MON_CFG)) begin
        monitor_config <= bus.wdata & CFG_MASK;
      end
    end
  end

  // Voltage ID: pins sampled each cycle, upper bits writable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vid_store <= RST_ZERO;
    end else begin
      vid_store[VID_PIN_W-1:0] <= vid_pins;
      if (wr_hit(bus, OFS_VID)) begin
        vid_store[7:VID_PIN_W] <= bus.wdata[7:VID_PIN_W];
      end
    end
  end

  // Bank select sits in the common area so it is never banked away
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bank_select <= RST_BANK;
    end else if (wr_hit(bus, OFS_BANK_SEL)) begin
      bank_select <= bus.wdata[BANK_W-1:0];
    end
  end

  // Banked limits and output enables
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        channel_high_limit[i] <= RST_HIGH;
        channel_low_limit[i]  <= RST_LOW;
        overtemp_limit[i]     <= RST_OT;
      end
      alert_en <= '0;
      ots_en   <= '0;
    end else if (bank_ok) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        if (bank_select == BANK_W'(i)) begin
          if (wr_hit(bus, OFS_CH_HIGH)) begin
            channel_high_limit[i] <= bus.wdata;
          end
          if (wr_hit(bus, OFS_CH_LOW)) begin
            channel_low_limit[i] <= bus.wdata;
          end
          if (wr_hit(bus, OFS_CH_OT)) begin
            overtemp_limit[i] <= bus.wdata;
          end
          if (wr_hit(bus, OFS_CH_CFGSTS)) begin
            alert_en[i] <= bus.wdata[CCS_ALERT_EN];
            ots_en[i]   <= bus.wdata[CCS_OTS_EN];
          end
        end
      end
    end
  end

  // Readouts; frozen in standby but still readable
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        channel_readout[i] <= RST_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        if (take_sample && sample.chan == BANK_W'(i)) begin
          channel_readout[i] <= sample.value;
        end
      end
    end
  end

  // Sticky flags; a hit in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      high_exceeded_flag <= '0;
      low_exceeded_flag  <= '0;
      ot_flag            <= '0;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        automatic logic clr = bank_ok && bank_select == BANK_W'(i)
                              && wr_hit(bus, OFS_CH_CFGSTS);
        automatic logic hit = take_sample && sample.chan == BANK_W'(i);
        high_exceeded_flag[i] <= (high_exceeded_flag[i]
                                  & ~(clr & bus.wdata[CCS_HIGH]))
                                 | (hit & hits.hi);
        low_exceeded_flag[i]  <= (low_exceeded_flag[i]
                                  & ~(clr & bus.wdata[CCS_LOW]))
                                 | (hit & hits.lo);
        ot_flag[i]            <= (ot_flag[i]
                                  & ~(clr & bus.wdata[CCS_OT]))
                                 | (hit & hits.ot);
      end
    end
  end

  // Read mux; data appear the cycle after the strobe only
  always_comb begin
    next_rd_data = RST_ZERO;
    if (!bus.rd) begin
      next_rd_data = RST_ZERO;
    end else if (bus.addr == OFS_EVT_STS0) begin
      next_rd_data = event_status_0;
    end else if (bus.addr == OFS_EVT_STS1) begin
      next_rd_data = event_status_1;
    end else if (bus.addr == OFS_SMI_EN0) begin
      next_rd_data = smi_enable_0;
    end else if (bus.addr == OFS_SMI_EN1) begin
      next_rd_data = smi_enable_1;
    end else if (bus.addr == OFS_IRQ_EN0) begin
      next_rd_data = irq_enable_0;
    end else if (bus.addr == OFS_IRQ_EN1) begin
      next_rd_data = irq_enable_1;
    end else if (bus.addr == OFS_VID) begin
      next_rd_data = vid_store;
    end else if (bus.addr == OFS_CONV_RATE) begin
      next_rd_data = conversion_rate;
    end else if (bus.addr == OFS_MON_CFG) begin
      next_rd_data = monitor_config;
    end else if (bus.addr == OFS_BANK_SEL) begin
      next_rd_data = {{(8-BANK_W){1'b0}}, bank_select};
    end else if (!bank_ok) begin
      next_rd_data = RST_ZERO;
    end else if (bus.addr == OFS_CH_CFGSTS) begin
      next_rd_data = channel_config_status;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        if (bank_select == BANK_W'(i)) begin
          if (bus.addr == OFS_CH_READOUT) begin
            next_rd_data = channel_readout[i];
          end else if (bus.addr == OFS_CH_HIGH) begin
            next_rd_data = channel_high_limit[i];
          end else if (bus.addr == OFS_CH_LOW) begin
            next_rd_data = channel_low_limit[i];
          end else if (bus.addr == OFS_CH_OT) begin
            next_rd_data = overtemp_limit[i];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= RST_ZERO;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // Event outputs, one cycle behind the flags
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq   <= 1'b0;
      smi   <= 1'b0;
      alert <= 1'b0;
      ots_n <= 1'b1;
    end else begin
      smi   <= |(event_status_0 & smi_enable_0)
               | |(event_status_1 & smi_enable_1);
      irq   <= |(event_status_0 & irq_enable_0)
               | |(event_status_1 & irq_enable_1);
      alert <= |((high_exceeded_flag | low_exceeded_flag) & alert_en);
      ots_n <= ~|(ot_flag & ots_en);
    end
  end

  // Converter control and shared reference
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meas_run      <= 1'b0;
      vref_internal <= 1'b0;
      conv_rate_out <= RST_CONV_RATE;
    end else begin
      meas_run      <= !standby;
      vref_internal <= monitor_config[CFG_INT_REF] | tms_int_ref;
      conv_rate_out <= conversion_rate;
    end
  end

endmodule
`default_nettype wire

//--- testbench/mlev_sys_model.sv
// System-side model: latches a shutdown request from the overtemperature pin
`timescale 1ns/1ps
`default_nettype none
module mlev_sys_model (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic ots_n,
  output logic      shutdown
);
  // Latched so a short low level is never lost
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shutdown <= 1'b0;
    end else if (!ots_n) begin
      shutdown <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- testbench/mlev_top_props.sv
// Port-level assertions for the monitor limit, event and bank block
`timescale 1ns/1ps
`default_nettype none
module mlev_top_props
  import mlev_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  input wire mlev_pkg::mlev_bus_t    bus,
  input wire logic [7:0]             rd_data,
  input wire mlev_pkg::mlev_sample_t sample,
  input wire logic [5:0]             vid_pins,
  input wire logic                   tms_int_ref,
  input wire logic [7:0]             conv_rate_out,
  input wire logic                   meas_run,
  input wire logic                   vref_internal,
  input wire logic                   irq,
  input wire logic                   smi,
  input wire logic                   ots_n,
  input wire logic                   alert
);
  logic wr_cr;
  assign wr_cr = bus.wr && (bus.addr == OFS_CONV_RATE);

  property p_rd_idle;
    @(posedge sys_clk) disable iff (!nrst) !bus.rd |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rsvd;
    @(posedge sys_clk) disable iff (!nrst) bus.rd && bus.addr == 4'hF |=> rd_data == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved offset read nonzero");
  // No disable here: the reset window is the very thing checked
  property p_rst_out;
    @(posedge sys_clk) !nrst |-> !irq && !smi && !alert && ots_n && !vref_internal;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs active in reset");
  property p_bank_hi;
    @(posedge sys_clk) disable iff (!nrst) bus.rd && bus.addr == OFS_BANK_SEL |=> rd_data[7:4] == 4'h0;
  endproperty
  a_bank_hi: assert property (p_bank_hi) else $error("bank select upper bits set");
  property p_standby;
    @(posedge sys_clk) disable iff (!nrst) bus.wr && bus.addr == OFS_MON_CFG && bus.wdata[0] |-> ##2 !meas_run;
  endproperty
  a_standby: assert property (p_standby) else $error("measuring in standby");
  property p_ref;
    @(posedge sys_clk) disable iff (!nrst) tms_int_ref ##1 tms_int_ref |=> vref_internal;
  endproperty
  a_ref: assert property (p_ref) else $error("shared reference not internal");
  property p_conv;
    @(posedge sys_clk) disable iff (!nrst) $changed(conv_rate_out) |-> $past(wr_cr) || $past(wr_cr, 2);
  endproperty
  a_conv: assert property (p_conv) else $error("rate output moved without write");
  property p_irq_rise;
    @(posedge sys_clk) disable iff (!nrst) $rose(irq) |-> $past(sample.valid, 2) || $past(bus.wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_alert_rise;
    @(posedge sys_clk) disable iff (!nrst) $rose(alert) |-> $past(sample.valid, 2) || $past(bus.wr, 2);
  endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("alert rose without cause");
  property p_ots_fall;
    @(posedge sys_clk) disable iff (!nrst) $fell(ots_n) |-> $past(sample.valid, 2) || $past(bus.wr, 2);
  endproperty
  a_ots_fall: assert property (p_ots_fall) else $error("overtemp pin fell without cause");
  property p_irq_fall;
    @(posedge sys_clk) disable iff (!nrst) $fell(irq) |-> $past(bus.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
endmodule

bind mlev_top mlev_top_props u_props (
  .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rd_data(rd_data), .sample(sample), .vid_pins(vid_pins),
  .tms_int_ref(tms_int_ref), .conv_rate_out(conv_rate_out), .meas_run(meas_run),
  .vref_internal(vref_internal), .irq(irq), .smi(smi), .ots_n(ots_n), .alert(alert)
);
`default_nettype wire

//--- testbench/mlev_top_tb.sv
// Self-checking bench with a behavioural register and limit model
`timescale 1ns/1ps
`default_nettype none
module mlev_top_tb;
  import mlev_pkg::*;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
  logic         sys_clk = 1'b0;
  // Starts high so the first reset is a real falling edge for the async flops
  logic         nrst = 1'b1;
  mlev_bus_t    bus = '0;
  mlev_sample_t sample = '0;
  logic [5:0]   vid_pins = 6'h15;
  logic         tms_int_ref = 1'b0;
  logic [7:0]   rd_data, conv_rate_out;
  logic         meas_run, vref_internal, irq, smi, ots_n, alert, shutdown;
  int           fail_count = 0;
  int           tests_run = 0;
  int           seed = 82;
  int           c[16];
  int           cc[13], fh[13], fl[13], fo[13], rdo[13], hl[13], ll[13], ol[13];
  bit           shut_seen;

  always #2 sys_clk = ~sys_clk;

  mlev_top dut (
    .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rd_data(rd_data), .sample(sample), .vid_pins(vid_pins),
    .tms_int_ref(tms_int_ref), .conv_rate_out(conv_rate_out), .meas_run(meas_run),
    .vref_internal(vref_internal), .irq(irq), .smi(smi), .ots_n(ots_n), .alert(alert)
  );
  mlev_sys_model u_sys (.sys_clk(sys_clk), .nrst(nrst), .ots_n(ots_n), .shutdown(shutdown));

  function automatic int sts(int r);
    int s = 0;
    for (int b = 0; b < 13; b++) begin
      if (fh[b] | fl[b] | fo[b]) begin
        if (r == 0 && b < 8) s |= 1 << b;
        if (r == 1 && b >= 8) s |= 1 << (b < 10 ? b - 8 : b - 7);
      end
    end
    return s;
  endfunction

  function automatic int mread(int a);
    int b = c[9];
    case (a)
      0, 1: return sts(a);
      6: return c[6] | vid_pins;
      10: return b < 13 ? cc[b] | fh[b] << 4 | fl[b] << 5 | fo[b] << 6 : 0;
      11: return b < 13 ? rdo[b] : 0;
      12: return b < 13 ? hl[b] : 0;
      13: return b < 13 ? ll[b] : 0;
      14: return b < 13 ? ol[b] : 0;
      15: return 0;
      default: return c[a];
    endcase
  endfunction

  task automatic wr(int a, int d);
    int b;
    @(posedge sys_clk);
    bus <= '{1'b1, 1'b0, a[3:0], d[7:0]};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
    b = c[9];
    case (a)
      2, 3, 4, 5, 7: c[a] = d & 255;
      6: c[6] = d & 8'hC0;
      8: c[8] = d & 3;
      9: c[9] = d & 15;
      10: if (b < 13) begin
        cc[b] = d & 3;
        if (d & 16) fh[b] = 0;
        if (d & 32) fl[b] = 0;
        if (d & 64) fo[b] = 0;
      end
      12: if (b < 13) hl[b] = d & 255;
      13: if (b < 13) ll[b] = d & 255;
      14: if (b < 13) ol[b] = d & 255;
      default: ;
    endcase
  endtask

  task automatic rd(int a);
    int e;
    @(posedge sys_clk);
    bus <= '{1'b0, 1'b1, a[3:0], 8'h00};
    e = mread(a);
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    `CHK("rd_data", e[7:0], rd_data)
  endtask

  task automatic smp(int ch, int v);
    @(posedge sys_clk);
    sample <= '{1'b1, ch[3:0], v[7:0]};
    @(posedge sys_clk);
    sample.valid <= 1'b0;
    if (ch < 13 && !(c[8] & 1)) begin
      rdo[ch] = v & 255;
      fh[ch] |= (v & 255) > hl[ch];
      fl[ch] |= (v & 255) < ll[ch];
      if (ch >= 10) fo[ch] |= (v & 255) > ol[ch];
    end
  endtask

  task automatic chk_out();
    int i, s, a, o;
    repeat (2) @(posedge sys_clk);
    #1;
    i = (sts(0) & c[4]) | (sts(1) & c[5]);
    s = (sts(0) & c[2]) | (sts(1) & c[3]);
    a = 0;
    o = 0;
    for (int b = 0; b < 13; b++) begin
      a |= cc[b] & 1 & (fh[b] | fl[b]);
      o |= (cc[b] >> 1) & fo[b];
    end
    shut_seen |= o;
    `CHK("irq", i != 0, irq)
    `CHK("smi", s != 0, smi)
    `CHK("alert", a, alert)
    `CHK("ots_n", !o, ots_n)
    `CHK("meas_run", !(c[8] & 1), meas_run)
    `CHK("vref_internal", (c[8] >> 1 & 1) | tms_int_ref, vref_internal)
    `CHK("conv_rate_out", c[7], conv_rate_out)
    `CHK("shutdown", shut_seen, shutdown)
  endtask

  task automatic do_reset();
    nrst <= 1'b0;
    shut_seen = 0;
    c = '{default: 0};
    cc  = '{default: 0};
    fh  = '{default: 0};
    fl  = '{default: 0};
    fo  = '{default: 0};
    rdo = '{default: 0};
    ll  = '{default: 0};
    hl = '{default: 255};
    ol = '{default: 255};
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("ots_n", 1'b1, ots_n)
    @(posedge sys_clk);
    nrst <= 1'b1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    do_reset();
    for (int a = 0; a < 16; a++) rd(a);
    wr(9, 12);
    for (int a = 10; a < 16; a++) rd(a);
    chk_out();
    $display("test defaults done");
    vid_pins <= 6'($random(seed));
    for (int n = 0; n < 40; n++) begin
      wr($random(seed) & 15, $random(seed) & 255);
      rd(n % 16);
    end
    chk_out();
    $display("test register access done");
    wr(8, 0);
    for (int a = 2; a < 6; a++) wr(a, 255);
    for (int b = 0; b < 13; b++) begin
      wr(9, b);
      wr(10, 8'h73);
      wr(12, 8'h80);
      wr(13, 8'h20);
      wr(14, 8'hC0);
      // Limits themselves must not trip the strict compares
      smp(b, 8'h80);
      smp(b, 8'h20);
      rd(10);
      smp(13 + b % 3, 8'hFF);
      for (int n = 0; n < 3; n++) smp(b, $random(seed));
      rd(10);
      rd(11);
      rd(0);
      rd(1);
      chk_out();
    end
    $display("test limits done");
    wr(8, 1);
    smp(12, 8'h00);
    wr(12, 8'h11);
    rd(11);
    rd(12);
    chk_out();
    wr(8, 0);
    $display("test standby done");
    rd(0);
    rd(1);
    for (int b = 0; b < 13; b++) begin
      if (fh[b] | fl[b] | fo[b]) begin
        wr(9, b);
        wr(10, 3);
        rd(10);
        wr(10, 8'h73);
        rd(10);
      end
    end
    rd(0);
    rd(1);
    chk_out();
    $display("test alert response done");
    @(posedge sys_clk);
    tms_int_ref <= 1'b1;
    chk_out();
    wr(8, 2);
    tms_int_ref <= 1'b0;
    chk_out();
    wr(8, 0);
    chk_out();
    $display("test reference done");
    do_reset();
    for (int a = 0; a < 16; a++) rd(a);
    chk_out();
    $display("test second reset done");
    test_done();
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
